// ### bench/ocmc_downstream_sink.sv
// downstream receiver model: sees a clock only from a running driver
`timescale 1ns/1ns
module ocmc_downstream_sink
	import ocmc_pkg::*;
(
	input wire ocmc_drive_s [7:0] channelDrive,
	output logic [7:0]            live
);
	for (genvar i = 0; i < 8; i++) begin : g_rx
		assign live[i] = channelDrive[i].running;
	end
endmodule // ocmc_downstream_sink

// ### bench/ocmc_output_mute_properties.sv
// checker: bus answer and mute output relations of the mute control block
`timescale 1ns/1ns
module ocmc_output_mute_properties
	import ocmc_pkg::*;
#(
	parameter int CHANNELS = OCMC_CHANNELS
) (
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic                  read,
	input wire logic                  write,
	input wire logic                  waitrequest,
	input wire logic                  sourceInvalid,
	input wire logic [CHANNELS-1:0]   channelMuted,
	input wire ocmc_drive_s [CHANNELS-1:0] channelDrive
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_ack; (read || write) && waitrequest |=> !waitrequest; endproperty
	a_ack: assert property (p_ack) else $error("request not answered");
	property p_one; !waitrequest |=> waitrequest; endproperty
	a_one: assert property (p_one) else $error("answer longer than one cycle");
	property p_idle; !(read || write) && waitrequest |=> waitrequest; endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_cause; |channelMuted |-> $past(sourceInvalid); endproperty
	a_cause: assert property (p_cause) else $error("mute without invalid source");
	property p_norm; !channelMuted[4] |-> channelDrive[4] == 6'h20; endproperty
	a_norm: assert property (p_norm) else $error("unmuted driver not normal");
	property p_drv; channelMuted[5] |-> channelDrive[5] != 6'h20; endproperty
	a_drv: assert property (p_drv) else $error("muted driver left normal");
	property p_rel; $fell(sourceInvalid) |=> channelMuted == '0; endproperty
	a_rel: assert property (p_rel) else $error("mute held after source valid");
endmodule // ocmc_output_mute_properties
bind ocmc_output_mute ocmc_output_mute_properties #(.CHANNELS(CHANNELS)) i_props (.clk, .rst_n,
	.read, .write, .waitrequest, .sourceInvalid, .channelMuted, .channelDrive);

// ### bench/testbench.sv
// testbench: register access and mute behaviour of the mute control block
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
	$display("MISMATCH %0t got %h", $time, a); end end
module testbench
	import ocmc_pkg::*;
;
	logic clk = 0, rst_n = 0, read = 0, write = 0, sourceInvalid = 0, waitrequest;
	logic [3:0]  address = 0;
	logic [31:0] writedata = 0, readdata;
	logic [7:0]  channelMuted, live, readValue;
	ocmc_drive_s [7:0] channelDrive;
	int num_errors = 0, total_checks = 0;
	always #4 clk = ~clk;
	ocmc_output_mute i_ocmc_output_mute (.clk, .rst_n, .address, .read, .write, .writedata,
		.byteenable(4'hf), .readdata, .waitrequest, .sourceInvalid, .channelMuted, .channelDrive);
	ocmc_downstream_sink i_ocmc_downstream_sink (.channelDrive, .live);
	task give_verdict;
		if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		address <= a; writedata <= {24'h0, d}; write <= w; read <= !w;
		n = 0;
		do @(posedge clk); while (waitrequest !== 1'b0 && ++n < 20);
		if (n >= 20) begin num_errors++; give_verdict; end
		readValue = readdata[7:0];
		write <= 0; read <= 0;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		bus(0, 4'h0, 0); `CHK(readValue, 8'h55)
		bus(0, 4'h4, 0); `CHK(readValue, 8'hff)
		bus(0, 4'h6, 0); `CHK(readValue, 8'h00)
		bus(1, 4'h0, 8'he4); bus(1, 4'h4, 8'hf0);
		bus(0, 4'h0, 0); `CHK(readValue, 8'he4)
		sourceInvalid <= 1;
		for (int m = 0; m < 2; m++) begin
			bus(1, 4'hc, m ? 8'hf0 : 8'h00);
			repeat (2) @(posedge clk);
			`CHK(channelMuted, 8'he0)
			`CHK(channelDrive[4], 6'h20)
			`CHK(channelDrive[6:5], m ? 12'h921 : 12'h250)
			`CHK(channelDrive[7], m ? 6'h05 : 6'h06)
			`CHK(live[6:0], m ? 7'h7f : 7'h1f)
		end
		bus(0, 4'h8, 0); `CHK(readValue, 8'he0)
		bus(1, 4'h4, 8'h0f);
		repeat (2) @(posedge clk);
		`CHK(channelMuted, 8'h0f)
		`CHK(channelDrive[0], 6'h10)
		`CHK(live, 8'hf0)
		sourceInvalid <= 0;
		repeat (2) @(posedge clk);
		`CHK(channelMuted, 8'h00)
		give_verdict;
	end
endmodule // testbench

// ### hw/ocmc_output_mute.sv
// output channel mute control: avalon-mm registers and per-channel driver mute decode
// Contract
// - channel 4 mute level is a two-bit read-write field at bits 1:0, reset to 1.
// - the mute level shapes the muted driver, and level zero (bypass) stops muting from happening at all.
// - differential mode levels are bypass, power down to common mode, force high, force low.
// - cmos mode levels are bypass, n leg low, p leg low, both legs low.
// - eight read-write auto-disable bits, channel n at bit n, each reset to 1.
// - an enabled channel is disabled while the selected source is invalid, unless its mute level is zero.
// - a channel whose auto-disable bit is zero keeps running regardless of the source.
// - each channel's automatic mute is independent of every other channel.
// - channels 5, 6 and 7 mute levels sit at bits 3:2, 5:4, 7:6, reset to 1, same encoding.
`timescale 1ns/1ns
module ocmc_output_mute
	import ocmc_pkg::*;
#(
	parameter int CHANNELS = OCMC_CHANNELS
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic [3:0]           address,
	input  wire logic                 read,
	input  wire logic                 write,
	input  wire logic [31:0]          writedata,
	input  wire logic [3:0]           byteenable,
	output logic      [31:0]          readdata,
	output logic                      waitrequest,
	input  wire logic                 sourceInvalid,
	output logic      [CHANNELS-1:0]  channelMuted,
	output ocmc_drive_s [CHANNELS-1:0] channelDrive
);

	// drive word of a driver that runs normally
	localparam ocmc_drive_s DRIVE_NORMAL = ocmc_drive_s'(6'h20);

	logic [7:0]                 levelReg_ff;
	logic [7:0]                 enableReg_ff;
	logic [7:0]                 cmosMode_ff;
	logic [31:0]                readdata_ff;
	logic                       waitrequest_ff;
	ocmc_bus_e                  busState_ff;
	logic [CHANNELS-1:0]        muted_ff;
	ocmc_drive_s [CHANNELS-1:0] drive_ff;

	// one request is taken per idle cycle; its answer stands for exactly one cycle
	wire         request   = read | write;
	wire         busIdle   = busState_ff == OCMC_BUS_IDLE;
	wire         busAccept = request & busIdle;
	wire         hitLevel  = address == OCMC_ADDR_LEVEL;
	wire         hitEnable = address == OCMC_ADDR_ENABLE;
	wire         hitStatus = address == OCMC_ADDR_STATUS;
	wire         hitMode   = address == OCMC_ADDR_MODE;
	wire         lowLane   = byteenable[0];
	wire         wrLevel   = busAccept & write & hitLevel & lowLane;
	wire         wrEnable  = busAccept & write & hitEnable & lowLane;
	wire         wrMode    = busAccept & write & hitMode & lowLane;
	// writes land at the edge that accepts the request
	wire [7:0]   nxt_levelReg  = wrLevel  ? writedata[7:0] : levelReg_ff;
	wire [7:0]   nxt_enableReg = wrEnable ? writedata[7:0] : enableReg_ff;
	wire [7:0]   nxt_cmosMode  = wrMode   ? writedata[7:0] : cmosMode_ff;
	wire [31:0]  nxt_readdata = hitLevel  ? {24'h000000, levelReg_ff} :
	                            hitEnable ? {24'h000000, enableReg_ff} :
	                            hitStatus ? {24'h000000, muted_ff[7:0]} :
	                            hitMode   ? {24'h000000, cmosMode_ff} : OCMC_UNMAPPED_DATA;
	// read data is captured at acceptance and held until the next request
	wire [31:0]  nxt_readHold = busAccept ? nxt_readdata : readdata_ff;
	wire ocmc_bus_e nxt_busState = busAccept ? OCMC_BUS_ACK : OCMC_BUS_IDLE;
	wire         nxt_waitrequest = ~busAccept;

	assign waitrequest = waitrequest_ff;
	assign readdata    = readdata_ff;
	assign channelMuted = muted_ff;
	assign channelDrive = drive_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busState_ff    <= OCMC_BUS_IDLE;
			waitrequest_ff <= 1'b1;
			readdata_ff    <= OCMC_UNMAPPED_DATA;
			levelReg_ff    <= OCMC_LEVEL_RESET;
			enableReg_ff   <= OCMC_ENABLE_RESET;
			cmosMode_ff    <= OCMC_MODE_RESET;
		end else begin
			busState_ff    <= nxt_busState;
			waitrequest_ff <= nxt_waitrequest;
			readdata_ff    <= nxt_readHold;
			levelReg_ff    <= nxt_levelReg;
			enableReg_ff   <= nxt_enableReg;
			cmosMode_ff    <= nxt_cmosMode;
		end
	end

	// channels below the first level field have no field of their own and mute at level one
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
			localparam bit HAS_LEVEL = ch >= OCMC_FIRST_LEVEL_CH &&
			                           ch < OCMC_FIRST_LEVEL_CH + OCMC_LEVEL_CHANNELS;
			wire         muteNow = enableReg_ff[ch] & sourceInvalid;
			wire         isCmos  = cmosMode_ff[ch];
			ocmc_level_e lvl;
			ocmc_drive_s diffDrive;
			ocmc_drive_s cmosDrive;
			if (HAS_LEVEL) begin : g_lvl
				assign lvl = ocmc_level_e'(levelReg_ff[(ch-OCMC_FIRST_LEVEL_CH)*OCMC_LEVEL_W
				             +: OCMC_LEVEL_W]);
			end else begin : g_fix
				assign lvl = OCMC_LVL_ONE;
			end
			// level zero leaves the driver alone even while the mute condition holds
			wire         applyMute = muteNow & (lvl != OCMC_LVL_BYPASS);
			wire ocmc_drive_s nxt_drive = !applyMute ? DRIVE_NORMAL :
			                              isCmos     ? cmosDrive : diffDrive;

			// differential driver: power down, or hold a static level on both legs
			always_comb begin
				case (lvl)
					OCMC_LVL_BYPASS: begin
						diffDrive.running    = 1'b1;
						diffDrive.powerDown  = 1'b0;
						diffDrive.forceHighP = 1'b0;
						diffDrive.forceLowP  = 1'b0;
						diffDrive.forceHighN = 1'b0;
						diffDrive.forceLowN  = 1'b0;
					end
					OCMC_LVL_ONE: begin
						diffDrive.running    = 1'b0;
						diffDrive.powerDown  = 1'b1;
						diffDrive.forceHighP = 1'b0;
						diffDrive.forceLowP  = 1'b0;
						diffDrive.forceHighN = 1'b0;
						diffDrive.forceLowN  = 1'b0;
					end
					OCMC_LVL_TWO: begin
						diffDrive.running    = 1'b0;
						diffDrive.powerDown  = 1'b0;
						diffDrive.forceHighP = 1'b1;
						diffDrive.forceLowP  = 1'b0;
						diffDrive.forceHighN = 1'b0;
						diffDrive.forceLowN  = 1'b1;
					end
					OCMC_LVL_THREE: begin
						diffDrive.running    = 1'b0;
						diffDrive.powerDown  = 1'b0;
						diffDrive.forceHighP = 1'b0;
						diffDrive.forceLowP  = 1'b1;
						diffDrive.forceHighN = 1'b1;
						diffDrive.forceLowN  = 1'b0;
					end
					default: begin
						diffDrive.running    = 1'b1;
						diffDrive.powerDown  = 1'b0;
						diffDrive.forceHighP = 1'b0;
						diffDrive.forceLowP  = 1'b0;
						diffDrive.forceHighN = 1'b0;
						diffDrive.forceLowN  = 1'b0;
					end
				endcase
			end

			// cmos driver: a leg that is not forced low keeps toggling
			always_comb begin
				case (lvl)
					OCMC_LVL_BYPASS: begin
						cmosDrive.running    = 1'b1;
						cmosDrive.powerDown  = 1'b0;
						cmosDrive.forceHighP = 1'b0;
						cmosDrive.forceLowP  = 1'b0;
						cmosDrive.forceHighN = 1'b0;
						cmosDrive.forceLowN  = 1'b0;
					end
					OCMC_LVL_ONE: begin
						cmosDrive.running    = 1'b1;
						cmosDrive.powerDown  = 1'b0;
						cmosDrive.forceHighP = 1'b0;
						cmosDrive.forceLowP  = 1'b0;
						cmosDrive.forceHighN = 1'b0;
						cmosDrive.forceLowN  = 1'b1;
					end
					OCMC_LVL_TWO: begin
						cmosDrive.running    = 1'b1;
						cmosDrive.powerDown  = 1'b0;
						cmosDrive.forceHighP = 1'b0;
						cmosDrive.forceLowP  = 1'b1;
						cmosDrive.forceHighN = 1'b0;
						cmosDrive.forceLowN  = 1'b0;
					end
					OCMC_LVL_THREE: begin
						cmosDrive.running    = 1'b0;
						cmosDrive.powerDown  = 1'b0;
						cmosDrive.forceHighP = 1'b0;
						cmosDrive.forceLowP  = 1'b1;
						cmosDrive.forceHighN = 1'b0;
						cmosDrive.forceLowN  = 1'b1;
					end
					default: begin
						cmosDrive.running    = 1'b1;
						cmosDrive.powerDown  = 1'b0;
						cmosDrive.forceHighP = 1'b0;
						cmosDrive.forceLowP  = 1'b0;
						cmosDrive.forceHighN = 1'b0;
						cmosDrive.forceLowN  = 1'b0;
					end
				endcase
			end

			// registered so the drive follows the inputs one cycle later
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					muted_ff[ch] <= 1'b0;
					drive_ff[ch] <= DRIVE_NORMAL;
				end else begin
					muted_ff[ch] <= applyMute;
					drive_ff[ch] <= nxt_drive;
				end
			end
		end
	endgenerate

endmodule // ocmc_output_mute

// ### hw/ocmc_pkg.sv
// package: register map, field layout and mute encodings for output channel mute control
package ocmc_pkg;
	localparam int          OCMC_CHANNELS       = 8;
	localparam int          OCMC_LEVEL_CHANNELS = 4;
	localparam int          OCMC_FIRST_LEVEL_CH = 4;
	localparam logic [3:0]  OCMC_ADDR_LEVEL     = 4'h0;
	localparam logic [3:0]  OCMC_ADDR_ENABLE    = 4'h4;
	localparam logic [3:0]  OCMC_ADDR_STATUS    = 4'h8;
	localparam logic [3:0]  OCMC_ADDR_MODE      = 4'hc;
	localparam logic [7:0]  OCMC_LEVEL_RESET    = 8'h55;
	localparam logic [7:0]  OCMC_ENABLE_RESET   = 8'hff;
	localparam logic [7:0]  OCMC_MODE_RESET     = 8'h00;
	localparam logic [31:0] OCMC_UNMAPPED_DATA  = 32'h00000000;
	localparam int          OCMC_LEVEL_W        = 2;

	typedef enum logic [1:0] {
		OCMC_LVL_BYPASS = 2'h0,
		OCMC_LVL_ONE    = 2'h1,
		OCMC_LVL_TWO    = 2'h2,
		OCMC_LVL_THREE  = 2'h3
	} ocmc_level_e;

	// per-leg drive of one output driver
	typedef struct packed {
		logic running;
		logic powerDown;
		logic forceHighP;
		logic forceLowP;
		logic forceHighN;
		logic forceLowN;
	} ocmc_drive_s;

	typedef enum logic [1:0] {
		OCMC_BUS_IDLE = 2'b01,
		OCMC_BUS_ACK  = 2'b10
	} ocmc_bus_e;
endpackage
